// ### rtl/cisc_pkg.sv
package cisc_pkg;

	// Input function codes
	localparam logic [7:0] FN_BLOCK_NO = 8'h08;
	localparam logic [7:0] FN_BLOCK_NC = 8'h09;
	localparam logic [7:0] FN_RAMP_HOLD = 8'h0a;
	localparam logic [7:0] FN_RAISE = 8'h10;
	localparam logic [7:0] FN_LOWER = 8'h11;
	localparam logic [7:0] FN_MULTI_STEP = 8'h03;

	// Register byte offsets
	localparam logic [7:0] OFS_FUNC0 = 8'h00;
	localparam logic [7:0] OFS_FUNC4 = 8'h10;
	localparam logic [7:0] OFS_CONFIG = 8'h14;
	localparam logic [7:0] OFS_UPPER = 8'h18;
	localparam logic [7:0] OFS_LOWER = 8'h1c;
	localparam logic [7:0] OFS_MLOWER = 8'h20;
	localparam logic [7:0] OFS_ACCEL = 8'h24;
	localparam logic [7:0] OFS_DECEL = 8'h28;
	localparam logic [7:0] OFS_ANALOG = 8'h2c;
	localparam logic [7:0] OFS_STEP_REF = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_OUT_FREQ = 8'h38;
	localparam logic [7:0] OFS_REF = 8'h3c;
	localparam logic [7:0] OFS_NV_FREQ = 8'h40;

	// Config fields
	localparam int CFG_HOLD_MEM = 0;
	localparam int CFG_RUN_SRC_LSB = 4;
	localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;

	// Reset values; frequency limits in tenths of a percent of maximum frequency
	localparam logic [10:0] UPPER_RESET = 11'h3e8;
	localparam logic [10:0] LIMIT_MAX = 11'h44c;
	localparam logic [10:0] LOWER_RESET = 11'h000;
	localparam logic [15:0] RAMP_RESET = 16'h0064;
	localparam logic [7:0] FUNC_RESET = 8'h00;

	// Raise/lower step interval
	localparam int STEP_TIME_MS = 10;
	localparam int CLK_HZ = 10_000_000;
	localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_TIME_MS;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'h0,
		RESP_SLVERR = 2'h2
	} cisc_resp_t;

	typedef enum {
		ST_STOPPED,
		ST_RUNNING,
		ST_BLOCKED,
		ST_SEARCH
	} cisc_state_t;

endpackage : cisc_pkg

// ### rtl/cisc_core.sv
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cisc_core
	import cisc_pkg::*;
#(
	parameter int NUM_INPUTS = 5,
	parameter int STEP_COUNT = STEP_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Terminals and sequence
	input wire logic [NUM_INPUTS-1:0] prog_input,
	input wire logic run_terminal,
	input wire logic run_other,
	input wire logic power_up_pulse,
	// Drive side
	output logic output_enable,
	output logic search_start,
	output logic [10:0] search_freq,
	output logic [10:0] out_freq,
	output logic invalid_input_assignment_error,
	// AXI4-Lite
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] func_reg [NUM_INPUTS];
	logic hold_memory_select_reg;
	logic [1:0] run_source_select_reg;
	logic [10:0] reference_upper_limit_reg;
	logic [10:0] reference_lower_limit_reg;
	logic [10:0] master_reference_lower_limit_reg;
	logic [15:0] accel_reg;
	logic [15:0] decel_reg;
	logic [10:0] analog_reference_input_reg;
	logic [10:0] step_ref_reg;
	logic [10:0] ref_reg;
	logic [10:0] held_reference_retention_reg;
	logic [NUM_INPUTS-1:0] sync1_reg;
	logic [NUM_INPUTS-1:0] sync2_reg;
	logic [NUM_INPUTS-1:0] is_blk_no, is_blk_nc, is_hold, is_up, is_dn, is_step;
	logic blocked, hold_in, up_in, dn_in, has_up, has_dn, has_hold, step_sel;
	logic run_cmd, run_prev_reg, up_prev_reg, dn_prev_reg;
	logic [15:0] ramp_cnt_reg;
	logic [$clog2(STEP_COUNT+1)-1:0] step_cnt_reg;
	logic [10:0] eff_lower, eff_target, blk_ref_reg;
	cisc_state_t state_reg;

	// ****************************************
	// Input decode
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= prog_input;
			sync2_reg <= sync1_reg;
		end
	end

	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_dec
		assign is_blk_no[i] = func_reg[i] == FN_BLOCK_NO;
		assign is_blk_nc[i] = func_reg[i] == FN_BLOCK_NC;
		assign is_hold[i] = func_reg[i] == FN_RAMP_HOLD;
		assign is_up[i] = func_reg[i] == FN_RAISE;
		assign is_dn[i] = func_reg[i] == FN_LOWER;
		assign is_step[i] = func_reg[i] == FN_MULTI_STEP;
	end

	assign has_up = |is_up;
	assign has_dn = |is_dn;
	assign has_hold = |is_hold;
	assign blocked = |(is_blk_no & sync2_reg) | |(is_blk_nc & ~sync2_reg);
	assign hold_in = |(is_hold & sync2_reg);
	assign up_in = |(is_up & sync2_reg);
	assign dn_in = |(is_dn & sync2_reg);
	assign run_cmd = (run_source_select_reg == RUN_SRC_TERMINAL) ? run_terminal : run_other;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			invalid_input_assignment_error <= 1'b0;
		end else begin
			invalid_input_assignment_error <= (has_up ^ has_dn) | ((has_up | has_dn) & has_hold);
		end
	end

	// ****************************************
	// Reference and limits
	// ****************************************
	// effective lower limit
	always_comb begin
		eff_lower = (analog_reference_input_reg > reference_lower_limit_reg) ?
			analog_reference_input_reg : reference_lower_limit_reg;
		if (master_reference_lower_limit_reg > eff_lower) begin
			eff_lower = master_reference_lower_limit_reg;
		end
	end

	assign step_sel = |(is_step & sync2_reg) & !(has_up && has_dn);

	always_comb begin
		if (has_up && has_dn) begin
			eff_target = ref_reg;
		end else if (step_sel) begin
			eff_target = step_ref_reg;
		end else begin
			eff_target = analog_reference_input_reg;
		end
		if (eff_target > reference_upper_limit_reg) begin
			eff_target = reference_upper_limit_reg;
		end
		if (eff_target < eff_lower) begin
			eff_target = eff_lower;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_reg <= '0;
			step_cnt_reg <= '0;
			up_prev_reg <= 1'b0;
			dn_prev_reg <= 1'b0;
		end else begin
			up_prev_reg <= up_in;
			dn_prev_reg <= dn_in;
			if (power_up_pulse) begin
				ref_reg <= hold_memory_select_reg ? held_reference_retention_reg : 11'h000;
			end else if (run_cmd && run_prev_reg &&
					((up_in && !up_prev_reg) || (dn_in && !dn_prev_reg)) &&
					!(up_in && dn_in) && state_reg == ST_STOPPED) begin
				ref_reg <= '0;
			end else if (run_cmd && (up_in ^ dn_in)) begin
				if (step_cnt_reg >= STEP_COUNT[$bits(step_cnt_reg)-1:0] - 1'b1) begin
					step_cnt_reg <= '0;
					if (up_in && ref_reg < reference_upper_limit_reg) begin
						ref_reg <= ref_reg + 11'h001;
					end else if (dn_in && ref_reg > eff_lower) begin
						ref_reg <= ref_reg - 11'h001;
					end
				end else begin
					step_cnt_reg <= step_cnt_reg + 1'b1;
				end
			end else begin
				step_cnt_reg <= '0;
				if (ref_reg < eff_lower) begin
					ref_reg <= eff_lower;
				end else if (ref_reg > reference_upper_limit_reg) begin
					ref_reg <= reference_upper_limit_reg;
				end
			end
		end
	end

	// ****************************************
	// Sequence and ramp
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_STOPPED;
			run_prev_reg <= 1'b0;
			output_enable <= 1'b0;
			search_start <= 1'b0;
			search_freq <= '0;
			blk_ref_reg <= '0;
		end else begin
			run_prev_reg <= run_cmd;
			search_start <= 1'b0;
			unique case (state_reg)
				ST_STOPPED: begin
					if (run_cmd && !blocked) begin
						state_reg <= ST_RUNNING;
						output_enable <= 1'b1;
					end
				end
				ST_RUNNING: begin
					if (blocked) begin
						state_reg <= ST_BLOCKED;
						output_enable <= 1'b0;
						blk_ref_reg <= eff_target;
					end else if (!run_cmd && out_freq == '0) begin
						state_reg <= ST_STOPPED;
						output_enable <= 1'b0;
					end
				end
				ST_BLOCKED: begin
					output_enable <= 1'b0;
					if (!blocked) begin
						state_reg <= run_cmd ? ST_SEARCH : ST_STOPPED;
					end
				end
				ST_SEARCH: begin
					search_start <= 1'b1;
					search_freq <= blk_ref_reg;
					output_enable <= 1'b1;
					state_reg <= ST_RUNNING;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_freq <= '0;
			ramp_cnt_reg <= '0;
		end else if (power_up_pulse) begin
			out_freq <= (hold_memory_select_reg && (has_hold || (has_up && has_dn))) ?
				held_reference_retention_reg : 11'h000;
		end else if (state_reg == ST_BLOCKED) begin
			out_freq <= '0;
			ramp_cnt_reg <= '0;
		end else if (state_reg == ST_SEARCH) begin
			out_freq <= blk_ref_reg;
		end else if (run_cmd && !run_prev_reg && hold_in && !hold_memory_select_reg) begin
			out_freq <= '0;
		end else if (hold_in && state_reg == ST_RUNNING) begin
			ramp_cnt_reg <= '0;
		end else begin
			logic up_dir;
			logic [10:0] goal;
			goal = (run_cmd && state_reg == ST_RUNNING) ? eff_target : 11'h000;
			up_dir = goal > out_freq;
			if (goal == out_freq) begin
				ramp_cnt_reg <= '0;
			end else if (ramp_cnt_reg >= (up_dir ? accel_reg : decel_reg)) begin
				ramp_cnt_reg <= '0;
				out_freq <= up_dir ? out_freq + 11'h001 : out_freq - 11'h001;
			end else begin
				ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_reference_retention_reg <= '0;
		end else if (hold_memory_select_reg) begin
			if (hold_in) begin
				held_reference_retention_reg <= out_freq;
			end else if (has_up && has_dn) begin
				held_reference_retention_reg <= ref_reg;
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_ok, w_ok;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [31:0] rd_val;
	logic rd_hit, wr_hit;

	assign wr_hit = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= OFS_ANALOG + 8'h04);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OKAY;
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_ok <= 1'b1;
				aw_addr_reg <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_ok <= 1'b1;
				w_data_reg <= s_wdata;
				s_wready <= 1'b0;
			end
			if (aw_ok && w_ok && !s_bvalid) begin
				s_bvalid <= 1'b1;
				s_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// Register writes; strobes ignored since every field sits in byte 0/1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				func_reg[i] <= FUNC_RESET;
			end
			hold_memory_select_reg <= 1'b0;
			run_source_select_reg <= RUN_SRC_TERMINAL;
			reference_upper_limit_reg <= UPPER_RESET;
			reference_lower_limit_reg <= LOWER_RESET;
			master_reference_lower_limit_reg <= LOWER_RESET;
			accel_reg <= RAMP_RESET;
			decel_reg <= RAMP_RESET;
			analog_reference_input_reg <= '0;
			step_ref_reg <= '0;
		end else if (aw_ok && w_ok && !s_bvalid && wr_hit) begin
			if (aw_addr_reg <= OFS_FUNC4) begin
				func_reg[aw_addr_reg[4:2]] <= w_data_reg[7:0];
			end
			unique case (aw_addr_reg)
				OFS_CONFIG: begin
					hold_memory_select_reg <= w_data_reg[CFG_HOLD_MEM];
					run_source_select_reg <= w_data_reg[CFG_RUN_SRC_LSB +: 2];
				end
				OFS_UPPER: reference_upper_limit_reg <= (w_data_reg[10:0] > LIMIT_MAX) ?
					LIMIT_MAX : w_data_reg[10:0];
				OFS_LOWER: reference_lower_limit_reg <= (w_data_reg[10:0] > LIMIT_MAX) ?
					LIMIT_MAX : w_data_reg[10:0];
				OFS_MLOWER: master_reference_lower_limit_reg <= (w_data_reg[10:0] > LIMIT_MAX) ?
					LIMIT_MAX : w_data_reg[10:0];
				OFS_ACCEL: accel_reg <= w_data_reg[15:0];
				OFS_DECEL: decel_reg <= w_data_reg[15:0];
				OFS_ANALOG: analog_reference_input_reg <= w_data_reg[10:0];
				OFS_STEP_REF: step_ref_reg <= w_data_reg[10:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = '0;
		if (s_araddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (s_araddr <= OFS_FUNC4) begin
			rd_val = {24'h0, func_reg[s_araddr[4:2]]};
		end else begin
			unique case (s_araddr)
				OFS_CONFIG: rd_val = {26'h0, run_source_select_reg, 3'h0, hold_memory_select_reg};
				OFS_UPPER: rd_val = {21'h0, reference_upper_limit_reg};
				OFS_LOWER: rd_val = {21'h0, reference_lower_limit_reg};
				OFS_MLOWER: rd_val = {21'h0, master_reference_lower_limit_reg};
				OFS_ACCEL: rd_val = {16'h0, accel_reg};
				OFS_DECEL: rd_val = {16'h0, decel_reg};
				OFS_ANALOG: rd_val = {21'h0, analog_reference_input_reg};
				OFS_STEP_REF: rd_val = {21'h0, step_ref_reg};
				OFS_STATUS: rd_val = {24'h0, hold_in, up_in, dn_in, blocked, output_enable,
					invalid_input_assignment_error, run_cmd, state_reg == ST_BLOCKED};
				OFS_OUT_FREQ: rd_val = {21'h0, out_freq};
				OFS_REF: rd_val = {21'h0, ref_reg};
				OFS_NV_FREQ: rd_val = {21'h0, held_reference_retention_reg};
				default: rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rdata <= rd_val;
			s_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end

endmodule : cisc_core
`default_nettype wire

// ### sim/cisc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cisc_chk
	import cisc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Drive side
	input wire logic output_enable,
	input wire logic search_start,
	input wire logic [10:0] out_freq,
	// Bus
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic s_rvalid,
	input wire logic s_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ****
	// Reset values and bus handshakes
	// ****
	sequence wr_take;
		s_awvalid && s_awready && s_wvalid && s_wready;
	endsequence
	sequence rd_take;
		s_arvalid && s_arready;
	endsequence
	reset_vals_a: assert property ($rose(aresetn) |-> !output_enable && out_freq == 11'h0
		&& !s_bvalid && !s_rvalid) else $error("state after reset wrong");
	wr_resp_a: assert property (wr_take |=> !s_awready && !s_wready ##1 s_bvalid)
		else $error("write answer late");
	b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write answer dropped");
	b_done_a: assert property (s_bvalid && s_bready |=> !s_bvalid && s_awready && s_wready)
		else $error("write channel not freed");
	rd_resp_a: assert property (rd_take |=> s_rvalid && !s_arready)
		else $error("read answer late");
	r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read answer dropped");
	// ****
	// Drive side
	// ****
	search_pulse_a: assert property (search_start |=> !search_start)
		else $error("search start not a pulse");
	freq_clamp_a: assert property (out_freq <= LIMIT_MAX)
		else $error("frequency above limit");
endmodule : cisc_chk
`default_nettype wire

// ### sim/cisc_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module cisc_contacts (
	// Clock
	input wire logic aclk,
	// Requested contact states
	input wire logic [4:0] sw,
	input wire logic run_sw,
	// Terminal levels
	output logic [4:0] prog_input,
	output logic run_terminal
);
	always_ff @(posedge aclk) begin
		run_terminal <= run_sw;
	end
	// Contacts move off the clock, the sync stage must absorb it
	assign #37 prog_input = sw;
endmodule : cisc_contacts
`default_nettype wire

// ### sim/cisc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module cisc_tb_top
	import cisc_pkg::*;
;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [4:0] sw = 5'h00;
	logic run_sw = 1'h0;
	logic run_other = 1'h0;
	logic power_up_pulse = 1'h0;
	logic [7:0] s_awaddr = 8'h00;
	logic [7:0] s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0] s_wstrb = 4'hf;
	logic s_awvalid = 1'h0;
	logic s_wvalid = 1'h0;
	logic s_bready = 1'h0;
	logic s_arvalid = 1'h0;
	logic s_rready = 1'h0;
	wire logic [4:0] prog_input;
	wire logic run_terminal, output_enable, search_start, invalid_input_assignment_error;
	wire logic [10:0] search_freq, out_freq;
	wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	wire logic [1:0] s_bresp, s_rresp;
	wire logic [31:0] s_rdata;
	int num_errors = 0;
	int n_checks = 0;
	logic [10:0] f;

	initial forever #50 aclk = ~aclk;

	cisc_core #(.STEP_COUNT(4)) dut (.aclk, .aresetn, .prog_input, .run_terminal, .run_other,
		.power_up_pulse, .output_enable, .search_start, .search_freq, .out_freq,
		.invalid_input_assignment_error, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	cisc_contacts sw_m (.aclk, .sw, .run_sw, .prog_input, .run_terminal);

	// ****
	// Bus and wait tasks
	// ****
	task stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task to(input logic t);
		if (t) begin
			num_errors++;
			stop_test;
		end
	endtask : to
	task idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (s_awready === 1'h1) s_awvalid <= 1'h0;
			if (s_wready === 1'h1) s_wvalid <= 1'h0;
			if (s_bvalid === 1'h1) break;
		end
		s_bready <= 1'h0;
		to(n == 99);
		`CHK("bresp", e, s_bresp)
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (s_arready === 1'h1) s_arvalid <= 1'h0;
			if (s_rvalid === 1'h1) break;
		end
		s_rready <= 1'h0;
		to(n == 99);
		`CHK("rresp", e, s_rresp)
		if (e == RESP_OKAY) `CHK("rdata", d, s_rdata)
	endtask : rd
	task wo(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, RESP_OKAY);
	endtask : wo
	task fn(input int i, input logic [7:0] c);
		wo(OFS_FUNC0 + 8'(4 * i), {24'h0, c});
	endtask : fn
	function automatic logic [10:0] got(input int k);
		case (k)
			0: return out_freq;
			1: return {10'h0, output_enable};
			2: return {10'h0, search_start};
			default: return {10'h0, invalid_input_assignment_error};
		endcase
	endfunction : got
	// Polls a drive-side output until it shows v
	task wt(input int k, input logic [10:0] v);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if (got(k) === v) break;
		end
		to(n == 3000);
		`CHK("wait", v, got(k))
	endtask : wt

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		rd(OFS_UPPER, {21'h0, UPPER_RESET}, RESP_OKAY);
		rd(OFS_LOWER, 32'h0, RESP_OKAY);
		rd(OFS_MLOWER, 32'h0, RESP_OKAY);
		rd(OFS_CONFIG, 32'h10, RESP_OKAY);
		rd(8'h44, 32'h0, RESP_SLVERR);
		wr(OFS_OUT_FREQ, 32'h5, RESP_SLVERR);
		wo(OFS_CONFIG, 32'h10);
		fn(0, FN_RAISE);
		wt(3, 11'h1);
		fn(1, FN_LOWER);
		wt(3, 11'h0);
		fn(2, FN_RAMP_HOLD);
		wt(3, 11'h1);
		fn(2, FUNC_RESET);
		wt(3, 11'h0);
		wo(OFS_UPPER, 32'h64);
		wo(OFS_LOWER, 32'h32);
		wo(OFS_ACCEL, 32'h0);
		wo(OFS_DECEL, 32'h0);
		run_sw <= 1'h1;
		wt(0, 11'h32);
		wo(OFS_ANALOG, 32'h50);
		wt(0, 11'h50);
		sw <= 5'h03;
		idle(40);
		`CHK("both", 11'h50, out_freq)
		fn(2, FN_MULTI_STEP);
		wo(OFS_STEP_REF, 32'h1f4);
		sw <= 5'h04;
		idle(40);
		`CHK("multi", 11'h50, out_freq)
		sw <= 5'h01;
		wt(0, 11'h64);
		idle(40);
		`CHK("upper", 11'h64, out_freq)
		sw <= 5'h00;
		fn(3, FN_BLOCK_NO);
		sw <= 5'h08;
		wt(1, 11'h0);
		sw <= 5'h00;
		wt(2, 11'h1);
		`CHK("search", 11'h64, search_freq)
		fn(3, FN_BLOCK_NC);
		wt(1, 11'h0);
		sw <= 5'h08;
		wt(1, 11'h1);
		run_sw <= 1'h0;
		sw <= 5'h00;
		for (int i = 0; i < 4; i++) fn(i, FUNC_RESET);
		wt(0, 11'h0);
		wo(OFS_ACCEL, 32'h9);
		fn(0, FN_RAMP_HOLD);
		sw <= 5'h01;
		idle(4);
		run_sw <= 1'h1;
		idle(40);
		`CHK("hold run", 11'h0, out_freq)
		sw <= 5'h00;
		wt(0, 11'h14);
		sw <= 5'h01;
		idle(5);
		f = out_freq;
		idle(50);
		`CHK("hold", f, out_freq)
		sw <= 5'h00;
		wt(0, f + 11'h2);
		wt(0, 11'h50);
		wo(OFS_CONFIG, 32'h11);
		sw <= 5'h01;
		idle(5);
		rd(OFS_NV_FREQ, 32'h50, RESP_OKAY);
		run_sw <= 1'h0;
		sw <= 5'h00;
		wt(0, 11'h0);
		// Slow decel keeps the restored value visible after power-up
		wo(OFS_DECEL, 32'h3e8);
		power_up_pulse <= 1'h1;
		idle(1);
		power_up_pulse <= 1'h0;
		wt(0, 11'h50);
		fn(0, FN_RAISE);
		fn(1, FN_LOWER);
		run_sw <= 1'h1;
		idle(4);
		sw <= 5'h01;
		wt(0, 11'h64);
		rd(OFS_NV_FREQ, 32'h64, RESP_OKAY);
		wo(OFS_DECEL, 32'h0);
		wo(OFS_CONFIG, 32'h01);
		wt(1, 11'h0);
		run_other <= 1'h1;
		wt(1, 11'h1);
		stop_test;
	end
endmodule : cisc_tb_top
bind cisc_core cisc_chk chk (.aclk, .aresetn, .output_enable, .search_start, .out_freq,
	.s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
	.s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready);
`default_nettype wire
